/* File: lcf_checker.sv */
// Concurrent checks on the filter's job and memory ports.
`timescale 1ns/1ps
module lcf_checker (
   // Clock and reset.
   input  wire logic                       i_core_clk,
   input  wire logic                       i_resetn,
   // Job control.
   input  wire logic                       i_start,
   input  wire logic [lcf_pkg::DIM_W-1:0]  i_width,
   input  wire logic [lcf_pkg::DIM_W-1:0]  i_height,
   input  wire logic                       o_busy,
   input  wire logic                       o_done,
   // Memory ports.
   input  wire logic                       o_rd_req,
   input  wire logic [lcf_pkg::ADDR_W-1:0] o_rd_addr,
   input  wire logic                       i_rd_gnt,
   input  wire logic                       i_rd_valid,
   input  wire logic                       o_wr_req,
   input  wire logic [lcf_pkg::ADDR_W-1:0] o_wr_addr,
   input  wire logic [lcf_pkg::PIX_W-1:0]  o_wr_data,
   input  wire logic                       i_wr_gnt
);
   import lcf_pkg::*;
   logic              prev_ok_reg;
   logic [ADDR_W-1:0] prev_addr_reg;
   default clocking @(posedge i_core_clk); endclocking
   default disable iff (!i_resetn);
   // Remembers the last granted write address within the current job.
   always_ff @(posedge i_core_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         prev_ok_reg   <= 1'b0;
         prev_addr_reg <= '0;
      end else if (i_start && !o_busy) begin
         prev_ok_reg <= 1'b0;
      end else if (o_wr_req && i_wr_gnt) begin
         prev_ok_reg   <= 1'b1;
         prev_addr_reg <= o_wr_addr;
      end
   end
   sequence s_take;
      i_start && !o_busy;
   endsequence
   sequence s_rd_wait;
      o_rd_req && !i_rd_gnt && !i_rd_valid;
   endsequence
   busy_on_start_a: assert property (s_take |=> o_busy)
      else $error("busy did not rise after start");
   zero_done_a: assert property (s_take ##0 (i_width == '0 || i_height == '0)
      |-> ##2 o_done) else $error("empty job did not finish in two cycles");
   rd_hold_a: assert property (s_rd_wait |=> o_rd_req && $stable(o_rd_addr))
      else $error("read request changed before it was answered");
   rd_release_a: assert property (o_rd_req && (i_rd_gnt || i_rd_valid)
      |=> !o_rd_req) else $error("read request held after answer");
   wr_hold_a: assert property (o_wr_req && !i_wr_gnt
      |=> o_wr_req && $stable({o_wr_addr, o_wr_data}))
      else $error("write request changed before grant");
   wr_raster_a: assert property (o_wr_req && i_wr_gnt && prev_ok_reg
      |-> o_wr_addr == prev_addr_reg + 32'h0000_0002)
      else $error("write address did not step by one pixel");
   done_ends_a: assert property (o_done |-> !o_busy && $past(o_busy))
      else $error("done not at the end of busy");
   done_pulse_a: assert property (o_done |=> !o_done)
      else $error("done longer than one cycle");
   idle_quiet_a: assert property (!o_busy |-> !o_rd_req && !o_wr_req)
      else $error("memory traffic while idle");
endmodule // lcf_checker

/* File: lcf_fifo.sv */
// Parameterised valid/ready FIFO for output pixels.
`timescale 1ns/1ps
module lcf_fifo #(
   parameter int WIDTH = 16,
   parameter int DEPTH = 16
) (
   // Clock and reset.
   input  wire logic   i_clk,
   input  wire logic   i_rst_n,
   // Stream sides.
   lcf_stream_if.snk   in_if,
   lcf_stream_if.src   out_if
);
   localparam int AW = $clog2(DEPTH);

   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW:0]      wr_ptr_reg;
   logic [AW:0]      rd_ptr_reg;
   logic             full;
   logic             empty;
   logic             push;
   logic             pop;

   assign empty = (wr_ptr_reg == rd_ptr_reg);
   assign full  = (wr_ptr_reg[AW] != rd_ptr_reg[AW]) &&
                  (wr_ptr_reg[AW-1:0] == rd_ptr_reg[AW-1:0]);
   assign in_if.ready  = !full;
   assign out_if.valid = !empty;
   assign out_if.data  = mem[rd_ptr_reg[AW-1:0]];
   assign push = in_if.valid && !full;
   assign pop  = out_if.ready && !empty;

   always_ff @(posedge i_clk) begin
      if (push) begin
         mem[wr_ptr_reg[AW-1:0]] <= in_if.data;
      end
   end

   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         wr_ptr_reg <= '0;
         rd_ptr_reg <= '0;
      end else begin
         if (push) begin
            wr_ptr_reg <= wr_ptr_reg + 1'b1;
         end
         if (pop) begin
            rd_ptr_reg <= rd_ptr_reg + 1'b1;
         end
      end
   end
endmodule // lcf_fifo

/* File: lcf_filter_top.sv */
// Top level of the memory-to-memory luma 3x3 convolution filter.
`timescale 1ns/1ps

// Summary of operation
// RQ1 - Nine coefficient 3x3 kernel, software programmable
// RQ2 - Sum of nine coefficient times pixel products
// RQ3 - Sum becomes the window centre pixel's luma
// RQ4 - Raster order, top-left to bottom-right
// RQ5 - Exactly one convolution per pixel
// RQ6 - Sixteen-bit pixels: luma byte, chroma byte
// RQ7 - Only luma enters the convolution
// RQ8 - Chroma passes through unchanged, same position
// RQ9 - Mover fetches input frame from memory
// RQ10 - Processed frame written back to memory
// RQ11 - Coefficients optionally read from memory
// RQ12 - Fixed mode uses constant gradient kernel
// RQ13 - Everything runs on one fabric clock
// RQ14 - Border taps replicate nearest edge pixel
// RQ15 - Result saturated to 0 through 255
module lcf_filter_top (
   // Clock and reset.
   input  wire logic                           i_core_clk,
   input  wire logic                           i_resetn,
   // Job control.
   input  wire logic                           i_start,
   input  wire logic                           i_fixed_mode,
   input  wire logic                           i_coef_from_mem,
   input  wire logic [lcf_pkg::COEF_VEC_W-1:0] i_coef,
   input  wire logic [lcf_pkg::DIM_W-1:0]      i_width,
   input  wire logic [lcf_pkg::DIM_W-1:0]      i_height,
   input  wire logic [lcf_pkg::ADDR_W-1:0]     i_src_base,
   input  wire logic [lcf_pkg::ADDR_W-1:0]     i_dst_base,
   input  wire logic [lcf_pkg::ADDR_W-1:0]     i_coef_base,
   output logic                                o_busy,
   output logic                                o_done,
   // Memory read port.
   output logic                                o_rd_req,
   output logic      [lcf_pkg::ADDR_W-1:0]     o_rd_addr,
   input  wire logic                           i_rd_gnt,
   input  wire logic                           i_rd_valid,
   input  wire logic [lcf_pkg::PIX_W-1:0]      i_rd_data,
   // Memory write port.
   output logic                                o_wr_req,
   output logic      [lcf_pkg::ADDR_W-1:0]     o_wr_addr,
   output logic      [lcf_pkg::PIX_W-1:0]      o_wr_data,
   input  wire logic                           i_wr_gnt
);
   import lcf_pkg::*;

   // Reset synchroniser.
   logic                  rst_sync1_reg;
   logic                  rst_sync2_reg;
   logic                  rst_n;

   // Job parameters held for the whole frame.
   logic [DIM_W-1:0]      width_reg;
   logic [DIM_W-1:0]      height_reg;
   logic [ADDR_W-1:0]     src_reg;
   logic [ADDR_W-1:0]     dst_reg;
   logic [ADDR_W-1:0]     coef_base_reg;
   logic                  fixed_reg;
   logic [COEF_VEC_W-1:0] coef_reg;
   logic [OFF_W-1:0]      total_reg;

   // Sequencer.
   lcf_state_t            state_reg;
   logic [DIM_W-1:0]      col_reg;
   logic [DIM_W-1:0]      row_reg;
   logic [1:0]            tap_r_reg;
   logic [1:0]            tap_c_reg;
   logic [3:0]            coef_idx_reg;
   logic [LUMA_W-1:0]     chroma_reg;
   logic                  rd_req_reg;
   logic [ADDR_W-1:0]     rd_addr_reg;
   logic                  busy_reg;
   logic                  done_reg;

   // Writer.
   logic                  wr_req_reg;
   logic [ADDR_W-1:0]     wr_addr_reg;
   logic [PIX_W-1:0]      wr_data_reg;
   logic [OFF_W-1:0]      wr_count_reg;

   // Combinational helpers.
   logic [DIM_W-1:0]      tap_col;
   logic [DIM_W-1:0]      tap_row;
   logic [OFF_W-1:0]      tap_off;
   logic [ADDR_W-1:0]     tap_addr;
   logic [ADDR_W-1:0]     coef_addr;
   logic [3:0]            tap_idx;
   logic                  last_col;
   logic                  last_row;
   logic                  last_tap;
   logic                  start_job;
   logic                  tap_take;
   logic                  emit_take;
   logic                  wr_free;
   logic [LUMA_W-1:0]     mac_result;

   lcf_stream_if #(.W(PIX_W)) push_if ();
   lcf_stream_if #(.W(PIX_W)) pop_if ();

   // The release is delayed by two edges of the one clock. [RQ13]
   always_ff @(posedge i_core_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         rst_sync1_reg <= 1'b0;
         rst_sync2_reg <= 1'b0;
      end else begin
         rst_sync1_reg <= 1'b1;
         rst_sync2_reg <= rst_sync1_reg;
      end
   end
   assign rst_n = rst_sync2_reg;

   assign start_job = (state_reg == ST_IDLE) && i_start;
   assign last_col  = (col_reg == width_reg - DIM_ONE);
   assign last_row  = (row_reg == height_reg - DIM_ONE);
   assign last_tap  = (tap_r_reg == KPOS_HI) && (tap_c_reg == KPOS_HI);
   assign tap_idx   = {2'h0, tap_r_reg} * KDIM + {2'h0, tap_c_reg};
   assign tap_take  = (state_reg == ST_TAP_WAIT) && i_rd_valid;
   assign emit_take = (state_reg == ST_EMIT) && push_if.ready;

   // Border taps are clamped onto the nearest edge pixel.
   always_comb begin
      case (tap_c_reg)
         KPOS_LO: begin
            tap_col = (col_reg == '0) ? col_reg
                                      : col_reg - DIM_ONE; // [RQ14]
         end
         KPOS_HI: begin
            tap_col = last_col ? col_reg : col_reg + DIM_ONE; // [RQ14]
         end
         default: begin
            tap_col = col_reg;
         end
      endcase
      case (tap_r_reg)
         KPOS_LO: begin
            tap_row = (row_reg == '0) ? row_reg
                                      : row_reg - DIM_ONE; // [RQ14]
         end
         KPOS_HI: begin
            tap_row = last_row ? row_reg : row_reg + DIM_ONE; // [RQ14]
         end
         default: begin
            tap_row = row_reg;
         end
      endcase
   end

   assign tap_off   = OFF_W'(tap_row) * OFF_W'(width_reg) +
                      OFF_W'(tap_col);
   assign tap_addr  = src_reg + ADDR_W'({tap_off, 1'b0}); // [RQ6]
   assign coef_addr = coef_base_reg + ADDR_W'({coef_idx_reg, 1'b0});

   // Job parameters are captured once per frame.
   always_ff @(posedge i_core_clk or negedge rst_n) begin
      if (!rst_n) begin
         width_reg     <= '0;
         height_reg    <= '0;
         src_reg       <= '0;
         dst_reg       <= '0;
         coef_base_reg <= '0;
         fixed_reg     <= 1'b0;
         total_reg     <= '0;
      end else if (start_job) begin
         width_reg     <= i_width;
         height_reg    <= i_height;
         src_reg       <= i_src_base;
         dst_reg       <= i_dst_base;
         coef_base_reg <= i_coef_base;
         fixed_reg     <= i_fixed_mode; // [RQ12]
         total_reg     <= OFF_W'(i_width) * OFF_W'(i_height); // [RQ5]
      end
   end

   // Coefficients come from the port or from memory, unless fixed.
   always_ff @(posedge i_core_clk or negedge rst_n) begin
      if (!rst_n) begin
         coef_reg <= '0;
      end else if (start_job && !i_coef_from_mem) begin
         coef_reg <= i_coef; // [RQ1]
      end else if ((state_reg == ST_COEF_WAIT) && i_rd_valid) begin
         coef_reg[{coef_idx_reg, 3'h0} +: COEF_W] <=
            i_rd_data[LUMA_LSB +: COEF_W]; // [RQ11]
      end
   end

   // Frame sequencer: one read per tap, nine taps per pixel.
   always_ff @(posedge i_core_clk or negedge rst_n) begin
      if (!rst_n) begin
         state_reg    <= ST_IDLE;
         col_reg      <= '0;
         row_reg      <= '0;
         tap_r_reg    <= '0;
         tap_c_reg    <= '0;
         coef_idx_reg <= '0;
         rd_req_reg   <= 1'b0;
         rd_addr_reg  <= '0;
      end else begin
         case (state_reg)
            ST_IDLE: begin
               if (i_start) begin
                  col_reg      <= '0; // [RQ4]
                  row_reg      <= '0;
                  tap_r_reg    <= '0;
                  tap_c_reg    <= '0;
                  coef_idx_reg <= '0;
                  if ((i_width == '0) || (i_height == '0)) begin
                     state_reg <= ST_DRAIN;
                  end else if (!i_fixed_mode && i_coef_from_mem) begin
                     state_reg <= ST_COEF_REQ; // [RQ11]
                  end else begin
                     state_reg <= ST_TAP_REQ;
                  end
               end
            end
            ST_COEF_REQ: begin
               rd_req_reg  <= 1'b1;
               rd_addr_reg <= coef_addr; // [RQ11]
               state_reg   <= ST_COEF_WAIT;
            end
            ST_COEF_WAIT: begin
               if (i_rd_gnt || i_rd_valid) begin
                  rd_req_reg <= 1'b0;
               end
               if (i_rd_valid) begin
                  if (coef_idx_reg == TAP_LAST) begin
                     coef_idx_reg <= '0;
                     state_reg    <= ST_TAP_REQ;
                  end else begin
                     coef_idx_reg <= coef_idx_reg + 1'b1;
                     state_reg    <= ST_COEF_REQ;
                  end
               end
            end
            ST_TAP_REQ: begin
               rd_req_reg  <= 1'b1;
               rd_addr_reg <= tap_addr; // [RQ9]
               state_reg   <= ST_TAP_WAIT;
            end
            ST_TAP_WAIT: begin
               if (i_rd_gnt || i_rd_valid) begin
                  rd_req_reg <= 1'b0;
               end
               if (i_rd_valid) begin
                  if (last_tap) begin
                     tap_r_reg <= '0;
                     tap_c_reg <= '0;
                     state_reg <= ST_EMIT;
                  end else if (tap_c_reg == KPOS_HI) begin
                     tap_c_reg <= '0;
                     tap_r_reg <= tap_r_reg + 1'b1;
                     state_reg <= ST_TAP_REQ;
                  end else begin
                     tap_c_reg <= tap_c_reg + 1'b1;
                     state_reg <= ST_TAP_REQ;
                  end
               end
            end
            ST_EMIT: begin
               if (push_if.ready) begin
                  if (last_col) begin
                     col_reg <= '0; // [RQ4]
                     row_reg <= row_reg + DIM_ONE;
                  end else begin
                     col_reg <= col_reg + DIM_ONE;
                  end
                  if (last_col && last_row) begin
                     state_reg <= ST_DRAIN; // [RQ5]
                  end else begin
                     state_reg <= ST_TAP_REQ;
                  end
               end
            end
            ST_DRAIN: begin
               if ((wr_count_reg == total_reg) && !wr_req_reg) begin
                  state_reg <= ST_IDLE;
               end
            end
            default: begin
               state_reg <= ST_IDLE;
            end
         endcase
      end
   end

   // The centre tap's chroma is kept for the output pixel.
   always_ff @(posedge i_core_clk or negedge rst_n) begin
      if (!rst_n) begin
         chroma_reg <= '0;
      end else if (tap_take && (tap_idx == TAP_CENTRE)) begin
         chroma_reg <= i_rd_data[CHROMA_LSB +: LUMA_W]; // [RQ8]
      end
   end

   lcf_mac u_mac (
      .i_clk       (i_core_clk),
      .i_rst_n     (rst_n),
      .i_clear     (emit_take || (state_reg == ST_IDLE)),
      .i_tap_valid (tap_take),
      .i_tap_idx   (tap_idx),
      .i_luma      (i_rd_data[LUMA_LSB +: LUMA_W]), // [RQ7]
      .i_fixed     (fixed_reg),
      .i_coefs     (coef_reg),
      .o_result    (mac_result)
   );

   // Filtered luma replaces the centre pixel's luma byte.
   assign push_if.valid = (state_reg == ST_EMIT);
   assign push_if.data  = {chroma_reg, mac_result}; // [RQ3] [RQ8] [RQ6]

   lcf_fifo #(
      .WIDTH (PIX_W),
      .DEPTH (FIFO_DEPTH)
   ) u_fifo (
      .i_clk   (i_core_clk),
      .i_rst_n (rst_n),
      .in_if   (push_if),
      .out_if  (pop_if)
   );

   // Writer: pixels leave in the same raster order they were made.
   assign wr_free      = !wr_req_reg || i_wr_gnt;
   assign pop_if.ready = wr_free;

   always_ff @(posedge i_core_clk or negedge rst_n) begin
      if (!rst_n) begin
         wr_req_reg   <= 1'b0;
         wr_addr_reg  <= '0;
         wr_data_reg  <= '0;
         wr_count_reg <= '0;
      end else if (start_job) begin
         wr_count_reg <= '0;
      end else if (wr_free) begin
         wr_req_reg <= pop_if.valid;
         if (pop_if.valid) begin
            wr_addr_reg  <= dst_reg +
                            ADDR_W'({wr_count_reg, 1'b0}); // [RQ10]
            wr_data_reg  <= pop_if.data;
            wr_count_reg <= wr_count_reg + 1'b1;
         end
      end
   end

   // Job status.
   always_ff @(posedge i_core_clk or negedge rst_n) begin
      if (!rst_n) begin
         busy_reg <= 1'b0;
         done_reg <= 1'b0;
      end else begin
         done_reg <= 1'b0;
         if (start_job) begin
            busy_reg <= 1'b1;
         end else if ((state_reg == ST_DRAIN) && !wr_req_reg &&
                      (wr_count_reg == total_reg)) begin
            busy_reg <= 1'b0;
            done_reg <= 1'b1;
         end
      end
   end

   assign o_busy    = busy_reg;
   assign o_done    = done_reg;
   assign o_rd_req  = rd_req_reg;
   assign o_rd_addr = rd_addr_reg;
   assign o_wr_req  = wr_req_reg;
   assign o_wr_addr = wr_addr_reg;
   assign o_wr_data = wr_data_reg;
endmodule // lcf_filter_top

/* File: lcf_mac.sv */
// Multiply-accumulate over the nine kernel taps with saturation.
`timescale 1ns/1ps
module lcf_mac
   import lcf_pkg::*;
(
   // Clock and reset.
   input  wire logic                  i_clk,
   input  wire logic                  i_rst_n,
   // Tap stream.
   input  wire logic                  i_clear,
   input  wire logic                  i_tap_valid,
   input  wire logic [3:0]            i_tap_idx,
   input  wire logic [LUMA_W-1:0]     i_luma,
   input  wire logic                  i_fixed,
   input  wire logic [COEF_VEC_W-1:0] i_coefs,
   // Result.
   output logic      [LUMA_W-1:0]     o_result
);
   logic [COEF_VEC_W-1:0]     kernel;
   logic signed [COEF_W-1:0]  coef;
   logic signed [PROD_W-1:0]  prod;
   logic signed [ACC_W-1:0]   acc_reg;

   assign kernel = i_fixed ? SOBEL_KERNEL : i_coefs; // [RQ12] [RQ1]
   assign coef   = kernel[{i_tap_idx, 3'h0} +: COEF_W];
   assign prod   = coef * $signed({1'b0, i_luma}); // [RQ2]

   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         acc_reg <= '0;
      end else if (i_clear) begin
         acc_reg <= '0;
      end else if (i_tap_valid) begin
         acc_reg <= acc_reg + ACC_W'(prod); // [RQ2]
      end
   end

   always_comb begin
      if (acc_reg < 0) begin
         o_result = '0; // [RQ15]
      end else if (acc_reg > SAT_MAX) begin
         o_result = SAT_MAX[LUMA_W-1:0]; // [RQ15]
      end else begin
         o_result = acc_reg[LUMA_W-1:0];
      end
   end
endmodule // lcf_mac

/* File: lcf_mem_model.sv */
// Behavioural system memory answering the filter's read and write ports.
`timescale 1ns/1ps
module lcf_mem_model (
   // Clock and pacing.
   input  wire logic                       i_clk,
   input  wire logic [3:0]                 i_lat,
   input  wire logic                       i_stall,
   input  wire logic                       i_clr,
   // Read port.
   input  wire logic                       i_rd_req,
   input  wire logic [lcf_pkg::ADDR_W-1:0] i_rd_addr,
   output logic                            o_rd_gnt,
   output logic                            o_rd_valid,
   output logic      [lcf_pkg::PIX_W-1:0]  o_rd_data,
   // Write port.
   input  wire logic                       i_wr_req,
   input  wire logic [lcf_pkg::ADDR_W-1:0] i_wr_addr,
   input  wire logic [lcf_pkg::PIX_W-1:0]  i_wr_data,
   output logic                            o_wr_gnt,
   // Traffic counts.
   output int                              o_rd_cnt,
   output int                              o_wr_cnt
);
   import lcf_pkg::*;
   logic [PIX_W-1:0] mem [0:4095];
   logic [3:0]       wait_reg = 4'h0;
   initial begin
      o_rd_gnt   = 1'b0;
      o_rd_valid = 1'b0;
      o_rd_data  = 16'h0000;
      o_wr_gnt   = 1'b0;
      o_rd_cnt   = 0;
      o_wr_cnt   = 0;
   end
   // Answers each read after i_lat idle cycles; data is garbled otherwise.
   always @(posedge i_clk) begin
      if (i_rd_req && !o_rd_valid && wait_reg >= i_lat) begin
         o_rd_valid <= 1'b1;
         o_rd_gnt   <= 1'b1;
         o_rd_data  <= mem[i_rd_addr[12:1]];
         wait_reg   <= 4'h0;
         o_rd_cnt   <= o_rd_cnt + 1;
      end else begin
         o_rd_valid <= 1'b0;
         o_rd_gnt   <= 1'b0;
         o_rd_data  <= ~o_rd_data;
         wait_reg   <= (i_rd_req && !o_rd_valid) ? wait_reg + 4'h1 : 4'h0;
      end
      o_wr_gnt <= i_wr_req && !i_stall && !o_wr_gnt;
      if (i_wr_req && o_wr_gnt) begin
         mem[i_wr_addr[12:1]] <= i_wr_data;
         o_wr_cnt <= o_wr_cnt + 1;
      end
      if (i_clr) begin
         o_rd_cnt <= 0;
         o_wr_cnt <= 0;
      end
   end
endmodule // lcf_mem_model

/* File: lcf_pkg.sv */
// Shared constants and types for the luma 3x3 convolution filter.
package lcf_pkg;
   // Data path widths.
   localparam int DIM_W      = 12;
   localparam int OFF_W      = 24;
   localparam int ADDR_W     = 32;
   localparam int PIX_W      = 16;
   localparam int LUMA_W     = 8;
   localparam int LUMA_LSB   = 0;
   localparam int CHROMA_LSB = 8;
   localparam int COEF_W     = 8;
   localparam int TAPS       = 9;
   localparam int COEF_VEC_W = 72;
   localparam int PROD_W     = 17;
   localparam int ACC_W      = 21;
   localparam int FIFO_DEPTH = 16;
   // Kernel walk positions.
   localparam logic [3:0] TAP_LAST   = 4'h8;
   localparam logic [3:0] TAP_CENTRE = 4'h4;
   localparam logic [3:0] KDIM       = 4'h3;
   localparam logic [1:0] KPOS_LO    = 2'h0;
   localparam logic [1:0] KPOS_HI    = 2'h2;
   localparam logic [DIM_W-1:0] DIM_ONE = 12'h001;
   // Horizontal gradient kernel, tap 0 in the low byte.
   localparam logic [COEF_VEC_W-1:0] SOBEL_KERNEL =
      72'h01_00ff_0200_fe01_00ff;
   localparam logic signed [ACC_W-1:0] SAT_MAX = 21'h00_00ff;
   // Sequencer states.
   typedef enum logic [2:0] {
      ST_IDLE,
      ST_COEF_REQ,
      ST_COEF_WAIT,
      ST_TAP_REQ,
      ST_TAP_WAIT,
      ST_EMIT,
      ST_DRAIN
   } lcf_state_t;
endpackage

/* File: lcf_stream_if.sv */
// Valid/ready pixel stream between the filter's own modules.
`timescale 1ns/1ps
interface lcf_stream_if #(parameter int W = 16);
   logic         valid;
   logic         ready;
   logic [W-1:0] data;
   modport src (output valid, output data, input ready);
   modport snk (input valid, input data, output ready);
endinterface

/* File: luma_conv3x3_filter_bench.sv */
// Self-checking bench for the luma 3x3 convolution filter.
`timescale 1ns/1ps
module luma_conv3x3_filter_bench;
   import lcf_pkg::*;
   localparam logic [71:0] ONES = 72'h01_0101_0101_0101_0101;
   localparam logic [71:0] GRAD = 72'h01_00ff_0200_fe01_00ff;
   logic                  clk = 1'b0, resetn = 1'b0, start = 1'b0;
   logic                  fixed = 1'b0, from_mem = 1'b0;
   logic                  stall = 1'b0, clr = 1'b0;
   logic [COEF_VEC_W-1:0] coef = '0;
   logic [DIM_W-1:0]      width = '0, height = '0;
   logic [3:0]            lat = 4'h0;
   logic                  busy, done, rd_req, rd_gnt, rd_valid, wr_req, wr_gnt;
   logic [ADDR_W-1:0]     rd_addr, wr_addr;
   logic [PIX_W-1:0]      rd_data, wr_data;
   int                    rd_cnt, wr_cnt, mismatches = 0, n_tests = 0;
   always #25 clk = ~clk;
   lcf_filter_top dut (.i_core_clk(clk), .i_resetn(resetn), .i_start(start),
      .i_fixed_mode(fixed), .i_coef_from_mem(from_mem), .i_coef(coef),
      .i_width(width), .i_height(height), .i_src_base(32'h0000_0000),
      .i_dst_base(32'h0000_1000), .i_coef_base(32'h0000_0c00),
      .o_busy(busy), .o_done(done), .o_rd_req(rd_req), .o_rd_addr(rd_addr),
      .i_rd_gnt(rd_gnt), .i_rd_valid(rd_valid), .i_rd_data(rd_data),
      .o_wr_req(wr_req), .o_wr_addr(wr_addr), .o_wr_data(wr_data),
      .i_wr_gnt(wr_gnt));
   lcf_mem_model u_mem (.i_clk(clk), .i_lat(lat), .i_stall(stall),
      .i_clr(clr), .i_rd_req(rd_req), .i_rd_addr(rd_addr),
      .o_rd_gnt(rd_gnt), .o_rd_valid(rd_valid), .o_rd_data(rd_data),
      .i_wr_req(wr_req), .i_wr_addr(wr_addr), .i_wr_data(wr_data),
      .o_wr_gnt(wr_gnt), .o_rd_cnt(rd_cnt), .o_wr_cnt(wr_cnt));
   task automatic check(input logic ok, input string msg);
      n_tests++;
      if (ok !== 1'b1) begin
         mismatches++;
         $display("CHECK FAILED at %0t: %s", $time, msg);
      end
   endtask
   task automatic tally_and_finish();
      $display("comparisons %0d mismatches %0d", n_tests, mismatches);
      if (mismatches == 0 && n_tests > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   function automatic logic [15:0] src_pix(input int i);
      logic [7:0] y, c;
      y = 8'(i * 37 + 200);
      c = 8'(i * 13 + 90);
      return {c, y};
   endfunction
   // Reference convolution with edge replication and clamping to a byte.
   function automatic logic [7:0] ref_luma(input logic [71:0] kv,
                                          input int w, h, r, c);
      int acc, rr, cc;
      logic [15:0] p;
      acc = 0;
      for (int k = 0; k < 9; k++) begin
         rr = r + k / 3 - 1;
         cc = c + k % 3 - 1;
         rr = rr < 0 ? 0 : (rr >= h ? h - 1 : rr);
         cc = cc < 0 ? 0 : (cc >= w ? w - 1 : cc);
         p = src_pix(rr * w + cc);
         acc += int'($signed(kv[8*k +: 8])) * int'(p[7:0]);
      end
      return acc < 0 ? 8'h00 : (acc > 255 ? 8'hff : 8'(acc));
   endfunction
   task automatic run_job(input logic fx, fm, input logic [71:0] ci, kv,
                          input int w, h, hold);
      int n;
      logic [15:0] e;
      for (int i = 0; i < w * h; i++) begin
         u_mem.mem[i] = src_pix(i);
         u_mem.mem[2048 + i] = 'x;
      end
      @(posedge clk);
      fixed    <= fx;
      from_mem <= fm;
      coef     <= ci;
      width    <= DIM_W'(w);
      height   <= DIM_W'(h);
      stall    <= hold > 0;
      start    <= 1'b1;
      clr      <= 1'b1;
      @(posedge clk);
      start <= 1'b0;
      clr   <= 1'b0;
      if (hold > 0) begin
         repeat (hold) @(negedge clk);
         check(rd_req === 1'b0 && wr_cnt == 0, "reader not held by full buffer");
         @(posedge clk);
         stall <= 1'b0;
      end
      for (n = 0; n < 5000; n++) begin
         @(negedge clk);
         if (done === 1'b1)
            break;
      end
      check(n < 5000, "job did not finish");
      if (n >= 5000)
         tally_and_finish();
      for (int i = 0; i < w * h; i++) begin
         e = src_pix(i);
         e[7:0] = ref_luma(kv, w, h, i / w, i % w);
         check(u_mem.mem[2048 + i] === e, "output pixel wrong");
      end
      check(wr_cnt == w * h, "write count wrong");
      check(rd_cnt == 9 * w * h + ((fm && !fx) ? 9 : 0), "read count wrong");
   endtask
   task automatic sc_prog();
      run_job(1'b0, 1'b0, ONES, ONES, 4, 3, 0);
      run_job(1'b0, 1'b0, 72'hff_ffff_ff08_ffff_ffff,
              72'hff_ffff_ff08_ffff_ffff, 4, 3, 0);
      run_job(1'b0, 1'b0, 72'h00_0000_0001_0000_0000,
              72'h00_0000_0001_0000_0000, 1, 1, 0);
      run_job(1'b0, 1'b0, 72'h02_00fe_0100_ff00_0003,
              72'h02_00fe_0100_ff00_0003, 3, 1, 0);
   endtask
   task automatic sc_fixed();
      run_job(1'b1, 1'b0, ONES, GRAD, 4, 3, 0);
      run_job(1'b1, 1'b1, ONES, GRAD, 3, 2, 0);
   endtask
   task automatic sc_memcoef();
      logic [71:0] kv;
      kv = 72'h02_fe01_0003_00ff_0101;
      for (int k = 0; k < 9; k++)
         u_mem.mem[1536 + k] = {8'ha5, kv[8*k +: 8]};
      run_job(1'b0, 1'b1, ONES, kv, 4, 3, 0);
   endtask
   task automatic sc_zero();
      run_job(1'b0, 1'b0, ONES, ONES, 0, 3, 0);
   endtask
   task automatic sc_stall();
      @(posedge clk);
      lat <= 4'h3;
      run_job(1'b0, 1'b0, GRAD, GRAD, 5, 4, 1500);
      @(posedge clk);
      lat <= 4'h0;
   endtask
   initial begin
      repeat (2) @(posedge clk);
      resetn <= 1'b1;
      repeat (4) @(posedge clk);
      sc_prog();
      sc_fixed();
      sc_memcoef();
      sc_zero();
      sc_stall();
      tally_and_finish();
   end
endmodule // luma_conv3x3_filter_bench
bind lcf_filter_top lcf_checker u_chk (.i_core_clk(i_core_clk),
   .i_resetn(i_resetn), .i_start(i_start), .i_width(i_width),
   .i_height(i_height), .o_busy(o_busy), .o_done(o_done),
   .o_rd_req(o_rd_req), .o_rd_addr(o_rd_addr), .i_rd_gnt(i_rd_gnt),
   .i_rd_valid(i_rd_valid), .o_wr_req(o_wr_req), .o_wr_addr(o_wr_addr),
   .o_wr_data(o_wr_data), .i_wr_gnt(i_wr_gnt));
